// [hw/ssf_status_flags.v]
/*
 * Status flag group with two-wire serial slave: saturation, engine error,
 * system interrupt detail and threshold cause flags.
 * Assumes engine event inputs are on sys_clk; scl/sda come from pins.
 */
// Functional notes
// R1 - eight per-channel light analog saturation flags, bit n for channel n
// R2 - flicker saturation flag bit 4 set by device, host clears writing one
// R3 - flicker busy bit 3 follows measurement in progress
// R4 - flicker timing error bit 2 set on flicker engine timing conflict
// R5 - proximity timing error bit 1 set when pulses overflow measure time
// R6 - modulator timing error bit 0 set when wait shorter than integration
// R7 - flicker system irq bit 3 set on result change when enabled
// R8 - sync error irq bit 0 set on frame sync error
// R9 - light above-upper cause flag in bit 7
// R10 - light below-lower cause flag in bit 6
// R11 - proximity one causes: bit 3 above upper, bit 2 below lower
// R12 - proximity zero causes: bit 1 above upper, bit 0 below lower
// R13 - light saturation summary points host to per-channel register
// R14 - system irq summary asserted when enabled and any detail event set
// R15 - all flags reset to zero; reserved bits read zero, ignore writes
// R16 - event flags stay latched until host clears them; busy and oscillator trim bits follow their inputs
`timescale 1ns/1ps
`default_nettype none
`include "ssf_regs.vh"

module ssf_status_flags (
	input  wire       sys_clk,
	input  wire       srst,
	input  wire       clk_en,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire [7:0] light_ch_analog_sat,
	input  wire       osc_trim_saturated,
	input  wire       osc_trim_done,
	input  wire       flicker_sat_event,
	input  wire       flicker_engine_busy,
	input  wire       flicker_timing_event,
	input  wire       proximity_timing_event,
	input  wire       modulator_timing_event,
	input  wire       flicker_result_changed,
	input  wire       flicker_sys_irq_enable,
	input  wire       sync_error_event,
	input  wire       sys_irq_enable,
	input  wire       light_irq_above_upper,
	input  wire       light_irq_below_lower,
	input  wire       prox1_irq_above_upper,
	input  wire       prox1_irq_below_lower,
	input  wire       prox0_irq_above_upper,
	input  wire       prox0_irq_below_lower,
	output reg        light_sat_summary,
	output reg        system_irq_summary
);

	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_RX     = 3'h1;
	localparam [2:0] ST_RX_ACK = 3'h2;
	localparam [2:0] ST_TX     = 3'h3;
	localparam [2:0] ST_TX_ACK = 3'h4;

	localparam [1:0] K_ADDR = 2'h0;
	localparam [1:0] K_PTR  = 2'h1;
	localparam [1:0] K_DATA = 2'h2;

	wire       scl_s;
	wire       sda_s;
	reg        scl_d;
	reg        sda_d;
	reg  [2:0] state;
	reg  [1:0] kind;
	reg  [3:0] bit_cnt;
	reg  [7:0] shreg;
	reg  [7:0] ptr;
	reg        rw;
	reg        nack;

	reg  [7:0] light_analog_saturation;
	reg  [7:0] engine_error_status;
	reg  [7:0] system_interrupt_detail;
	reg  [7:0] threshold_cause_flags;

	reg  [7:0] rd_data;
	reg        rd_take;
	reg        wr_take;
	reg  [7:0] next_sat;
	reg  [7:0] next_err;
	reg  [7:0] next_sys;
	reg  [7:0] next_cause;

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
	wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
	wire byte_done = (bit_cnt == `SSF_BITS_PER_BYTE);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	ssf_sync2 #(.RST_VAL(1'b1)) u_sync_scl (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.clk_en   (clk_en),
		.async_in (scl_in),
		.sync_out (scl_s)
	);

	ssf_sync2 #(.RST_VAL(1'b1)) u_sync_sda (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.clk_en   (clk_en),
		.async_in (sda_in),
		.sync_out (sda_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped pointers and reserved bits read zero
	always @*
	begin
		case (ptr)
			`SSF_ADDR_SAT:   rd_data = light_analog_saturation;
			`SSF_ADDR_ERR:   rd_data = engine_error_status;
			`SSF_ADDR_SYS:   rd_data = system_interrupt_detail;
			`SSF_ADDR_CAUSE: rd_data = threshold_cause_flags;
			default:         rd_data = `SSF_ZERO_BYTE; // R15
		endcase
	end

	// strobes: a byte is taken for sending, or a data byte was received
	always @*
	begin
		rd_take = 1'b0;
		wr_take = 1'b0;
		if (scl_fall && !bus_start && !bus_stop)
		begin
			if (state == ST_RX_ACK && kind == K_ADDR && rw)
				rd_take = 1'b1;
			if (state == ST_TX_ACK && !nack)
				rd_take = 1'b1;
			if (state == ST_RX && byte_done && kind == K_DATA)
				wr_take = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flag next values; read clears sticky flags except flicker saturation bit 4, a new event wins over clear
	always @*
	begin
		next_sat   = light_analog_saturation;
		next_err   = engine_error_status;
		next_sys   = system_interrupt_detail;
		next_cause = threshold_cause_flags;
		if (rd_take && ptr == `SSF_ADDR_SAT)
			next_sat = `SSF_ZERO_BYTE;
		if (rd_take && ptr == `SSF_ADDR_ERR)
		begin
			next_err[`SSF_ERR_FD_TRIG]   = 1'b0;
			next_err[`SSF_ERR_PROX_TRIG] = 1'b0;
			next_err[`SSF_ERR_MOD_TRIG]  = 1'b0;
		end
		if (wr_take && ptr == `SSF_ADDR_ERR && shreg[`SSF_ERR_FD_SAT])
			next_err[`SSF_ERR_FD_SAT] = 1'b0; // R2
		if (rd_take && ptr == `SSF_ADDR_SYS)
			next_sys = `SSF_ZERO_BYTE;
		if (rd_take && ptr == `SSF_ADDR_CAUSE)
			next_cause = `SSF_ZERO_BYTE;

		next_sat = next_sat | light_ch_analog_sat; // R1 R16
		next_err[`SSF_ERR_OSC_SAT]   = osc_trim_saturated;
		next_err[`SSF_ERR_OSC_DONE]  = osc_trim_done;
		next_err[`SSF_ERR_FLICKER_ENGINE_BUSY]   = flicker_engine_busy; // R3
		next_err[`SSF_ERR_FD_SAT]    = next_err[`SSF_ERR_FD_SAT] | flicker_sat_event; // R2 R16
		next_err[`SSF_ERR_FD_TRIG]   = next_err[`SSF_ERR_FD_TRIG] | flicker_timing_event; // R4
		next_err[`SSF_ERR_PROX_TRIG] = next_err[`SSF_ERR_PROX_TRIG] | proximity_timing_event; // R5
		next_err[`SSF_ERR_MOD_TRIG]  = next_err[`SSF_ERR_MOD_TRIG] | modulator_timing_event; // R6
		next_sys[`SSF_SYS_FLICKER]   = next_sys[`SSF_SYS_FLICKER]
			| (flicker_result_changed & flicker_sys_irq_enable); // R7
		next_sys[`SSF_SYS_SYNC]      = next_sys[`SSF_SYS_SYNC] | sync_error_event; // R8
		next_cause[`SSF_CAU_L_HI]    = next_cause[`SSF_CAU_L_HI] | light_irq_above_upper; // R9
		next_cause[`SSF_CAU_L_LO]    = next_cause[`SSF_CAU_L_LO] | light_irq_below_lower; // R10
		next_cause[`SSF_CAU_P1_HI]   = next_cause[`SSF_CAU_P1_HI] | prox1_irq_above_upper; // R11
		next_cause[`SSF_CAU_P1_LO]   = next_cause[`SSF_CAU_P1_LO] | prox1_irq_below_lower; // R11
		next_cause[`SSF_CAU_P0_HI]   = next_cause[`SSF_CAU_P0_HI] | prox0_irq_above_upper; // R12
		next_cause[`SSF_CAU_P0_LO]   = next_cause[`SSF_CAU_P0_LO] | prox0_irq_below_lower; // R12

		// reserved positions forced to zero
		next_err[6]     = 1'b0; // R15
		next_sys[7:4]   = 4'h0; // R15
		next_sys[2:1]   = 2'h0; // R15
		next_cause[5:4] = 2'h0; // R15
	end

	////////////////////////////////////////////////////////////////////////////
	// flag registers and summary outputs
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			light_analog_saturation <= `SSF_ZERO_BYTE; // R15
			engine_error_status     <= `SSF_ZERO_BYTE;
			system_interrupt_detail <= `SSF_ZERO_BYTE;
			threshold_cause_flags   <= `SSF_ZERO_BYTE;
			light_sat_summary       <= 1'b0;
			system_irq_summary      <= 1'b0;
		end
		else if (clk_en)
		begin
			light_analog_saturation <= next_sat;
			engine_error_status     <= next_err;
			system_interrupt_detail <= next_sys;
			threshold_cause_flags   <= next_cause;
			light_sat_summary       <= |next_sat; // R13
			system_irq_summary      <= sys_irq_enable & (|next_sys); // R14
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial slave: address, pointer, write data with auto-increment, reads
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
			state   <= ST_IDLE;
			kind    <= K_ADDR;
			bit_cnt <= `SSF_BIT_ZERO;
			shreg   <= `SSF_ZERO_BYTE;
			ptr     <= `SSF_ZERO_BYTE;
			rw      <= 1'b0;
			nack    <= 1'b0;
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else if (clk_en)
		begin
			scl_d   <= scl_s;
			sda_d   <= sda_s;
			sda_out <= 1'b0; // open drain: only ever pulls low
			if (bus_start)
			begin
				state   <= ST_RX;
				kind    <= K_ADDR;
				bit_cnt <= `SSF_BIT_ZERO;
				sda_oe  <= 1'b0;
			end
			else if (bus_stop)
			begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end
			else
			begin
				case (state)
					ST_IDLE:
					begin
						sda_oe <= 1'b0;
					end
					ST_RX:
					begin
						if (scl_rise && !byte_done)
						begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + `SSF_BIT_STEP;
						end
						else if (scl_fall && byte_done)
						begin
							if (kind == K_ADDR)
							begin
								if (shreg[7:1] == `SSF_DEV_ADDR)
								begin
									rw     <= shreg[0];
									sda_oe <= 1'b1;
									state  <= ST_RX_ACK;
								end
								else
									state <= ST_IDLE;
							end
							else
							begin
								if (kind == K_PTR)
									ptr <= shreg;
								else
									ptr <= ptr + `SSF_PTR_STEP;
								sda_oe <= 1'b1;
								state  <= ST_RX_ACK;
							end
						end
					end
					ST_RX_ACK:
					begin
						if (scl_fall)
						begin
							if (kind == K_ADDR && rw)
							begin
								sda_oe  <= ~rd_data[7];
								shreg   <= {rd_data[6:0], 1'b0};
								bit_cnt <= `SSF_BIT_FIRST;
								ptr     <= ptr + `SSF_PTR_STEP;
								state   <= ST_TX;
							end
							else
							begin
								sda_oe  <= 1'b0;
								kind    <= (kind == K_ADDR) ? K_PTR : K_DATA;
								bit_cnt <= `SSF_BIT_ZERO;
								state   <= ST_RX;
							end
						end
					end
					ST_TX:
					begin
						if (scl_fall)
						begin
							if (byte_done)
							begin
								sda_oe <= 1'b0;
								state  <= ST_TX_ACK;
							end
							else
							begin
								sda_oe  <= ~shreg[7];
								shreg   <= {shreg[6:0], 1'b0};
								bit_cnt <= bit_cnt + `SSF_BIT_STEP;
							end
						end
					end
					ST_TX_ACK:
					begin
						if (scl_rise)
							nack <= sda_s;
						else if (scl_fall)
						begin
							if (nack)
								state <= ST_IDLE;
							else
							begin
								sda_oe  <= ~rd_data[7];
								shreg   <= {rd_data[6:0], 1'b0};
								bit_cnt <= `SSF_BIT_FIRST;
								ptr     <= ptr + `SSF_PTR_STEP;
								state   <= ST_TX;
							end
						end
					end
					default:
					begin
						state  <= ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule // ssf_status_flags

`default_nettype wire

// [inc/ssf_regs.vh]
/*
 * Register map, field positions and constants of the sensor status flag group.
 * Assumes inclusion by its bare name from the design files.
 */
`ifndef SSF_REGS_VH
`define SSF_REGS_VH

// register pointers on the serial bus
`define SSF_ADDR_SAT        8'hB9
`define SSF_ADDR_ERR        8'hBA
`define SSF_ADDR_SYS        8'hBB
`define SSF_ADDR_CAUSE      8'hBD

// engine_error_status fields
`define SSF_ERR_OSC_SAT     7
`define SSF_ERR_OSC_DONE    5
`define SSF_ERR_FD_SAT      4
`define SSF_ERR_FLICKER_ENGINE_BUSY     3
`define SSF_ERR_FD_TRIG     2
`define SSF_ERR_PROX_TRIG   1
`define SSF_ERR_MOD_TRIG    0

// system_interrupt_detail fields
`define SSF_SYS_FLICKER     3
`define SSF_SYS_SYNC        0

// threshold_cause_flags fields
`define SSF_CAU_L_HI        7
`define SSF_CAU_L_LO        6
`define SSF_CAU_P1_HI       3
`define SSF_CAU_P1_LO       2
`define SSF_CAU_P0_HI       1
`define SSF_CAU_P0_LO       0

// reset and fill values
`define SSF_ZERO_BYTE       8'h00
`define SSF_ONES_BYTE       8'hFF
`define SSF_PTR_STEP        8'h01

// serial framing
`define SSF_BITS_PER_BYTE   4'h8
`define SSF_BIT_STEP        4'h1
`define SSF_BIT_ZERO        4'h0
`define SSF_BIT_FIRST       4'h1
`define SSF_DEV_ADDR        7'h2A

`endif

// [hw/ssf_sync2.v]
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the destination clock samples the input; only the second flop is read outside.
 */
`timescale 1ns/1ps
`default_nettype none

module ssf_sync2 #(
	parameter RST_VAL = 1'b1
) (
	input  wire sys_clk,
	input  wire srst,
	input  wire clk_en,
	input  wire async_in,
	output reg  sync_out
);

	reg meta;

	////////////////////////////////////////////////////////////////////////////
	// first flop feeds only the second
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			meta     <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else if (clk_en)
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule // ssf_sync2

`default_nettype wire

// [bench/ssf_status_flags_sva.sv]
/*
 * Port checker for the status flag block: summaries, gating and reset.
 * Assumes binding onto ssf_status_flags and one clock domain on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ssf_status_flags_sva (
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic       clk_en,
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic [7:0] light_ch_analog_sat,
	input wire logic       flicker_result_changed,
	input wire logic       flicker_sys_irq_enable,
	input wire logic       sync_error_event,
	input wire logic       sys_irq_enable,
	input wire logic       light_sat_summary,
	input wire logic       system_irq_summary
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// saturation summary follows channel flags
	AST_SAT_SET: assert property ((|light_ch_analog_sat) && clk_en |=> light_sat_summary)
		else $error("saturation summary missing");
	AST_SAT_ROSE: assert property ($rose(light_sat_summary) |-> $past(light_ch_analog_sat) != 8'h00)
		else $error("saturation summary without cause");
	// latched while the bus stays idle
	AST_SAT_HOLD: assert property (scl_in [*6] ##0 light_sat_summary |=> light_sat_summary)
		else $error("saturation flag lost while idle");

	////////////////////////////////////////////////////////////////////////
	// system interrupt summary causes and gating
	AST_SYNC_SET: assert property (sync_error_event && sys_irq_enable && clk_en |=> system_irq_summary)
		else $error("sync error not reported");
	AST_FLICK_SET: assert property (flicker_result_changed && flicker_sys_irq_enable && sys_irq_enable
		&& clk_en |=> system_irq_summary)
		else $error("flicker change not reported");
	AST_SYS_GATE: assert property (!sys_irq_enable && clk_en |=> !system_irq_summary)
		else $error("system summary high while disabled");
	AST_SYS_ROSE: assert property ($rose(system_irq_summary) |-> $past(sys_irq_enable))
		else $error("system summary rose while disabled");

	// reset clears outputs
	AST_RST_CLR: assert property (disable iff (1'b0) srst && clk_en |=>
		!light_sat_summary && !system_irq_summary && !sda_oe)
		else $error("outputs not cleared by reset");
endmodule // ssf_status_flags_sva

`default_nettype wire

// [bench/ssf_host.sv]
/*
 * Serial bus host model: start, stop, byte transfers, register read and write.
 * Assumes an open-drain data wire with pull-up; the bus clock idles high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssf_regs.vh"

module ssf_host (
	input  wire logic sys_clk,
	input  wire logic dev_oe,
	output logic      scl,
	output wire logic sda
);
	logic m_oe = 1'b0;
	logic ok;
	int   nak = 0;

	// wire level from both pull-down enables
	assign sda = ~(dev_oe | m_oe);
	initial scl = 1'b1;

	task tk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// one bit: data set in low half, sampled at end of high half
	task bx(input logic b, output logic r);
		tk(2);
		m_oe = ~b;
		tk(2);
		scl = 1'b1;
		tk(4);
		r = sda;
		scl = 1'b0;
	endtask

	task st;
		tk(2);
		m_oe = 1'b0;
		tk(2);
		scl = 1'b1;
		tk(4);
		m_oe = 1'b1;
		tk(4);
		scl = 1'b0;
	endtask

	task sp;
		tk(2);
		m_oe = 1'b1;
		tk(2);
		scl = 1'b1;
		tk(4);
		m_oe = 1'b0;
		tk(4);
	endtask

	// byte msb first, then ack slot; missing device ack is counted when last is set and the byte is not 8'hFF
	task by(input logic [7:0] d, output logic [7:0] q, input logic last);
		for (int i = 7; i >= 0; i--)
			bx(d[i], q[i]);
		bx(last, ok);
		if (last && d != 8'hFF && ok !== 1'b0)
			nak++;
	endtask

	task wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] x;
		st();
		by({`SSF_DEV_ADDR, 1'b0}, x, 1'b1);
		by(p, x, 1'b1);
		by(d, x, 1'b1);
		sp();
	endtask

	task rd(input logic [7:0] p, output logic [7:0] q);
		logic [7:0] x;
		st();
		by({`SSF_DEV_ADDR, 1'b0}, x, 1'b1);
		by(p, x, 1'b1);
		st();
		by({`SSF_DEV_ADDR, 1'b1}, x, 1'b1);
		by(8'hFF, q, 1'b1);
		sp();
	endtask
endmodule // ssf_host

`default_nettype wire

// [bench/ssf_status_flags_tb.sv]
/*
 * Testbench for the status flag block: reset, every flag, clearing, summaries.
 * Assumes the host model and checker files compile before this one.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssf_regs.vh"

module ssf_status_flags_tb;
	logic        sys_clk;
	logic        srst;
	logic        sda_out;
	logic        sda_oe;
	logic        lss;
	logic        sis;
	wire logic   scl;
	wire logic   sda;
	logic [19:0] ev = '0; // 7:0 sat, 13:8 cause, 14..19 fsat ftim ptim mtim fres sync
	logic [4:0]  lv = '0; // osc sat, osc done, busy, flicker irq en, sys irq en
	logic [7:0]  q;
	int          err_count = 0;
	int          cmp_count = 0;

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	ssf_host i_ssf_host (.sys_clk(sys_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

	ssf_status_flags i_ssf_status_flags (
		.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .light_ch_analog_sat(ev[7:0]),
		.osc_trim_saturated(lv[0]), .osc_trim_done(lv[1]), .flicker_sat_event(ev[14]),
		.flicker_engine_busy(lv[2]), .flicker_timing_event(ev[15]),
		.proximity_timing_event(ev[16]), .modulator_timing_event(ev[17]),
		.flicker_result_changed(ev[18]), .flicker_sys_irq_enable(lv[3]),
		.sync_error_event(ev[19]), .sys_irq_enable(lv[4]),
		.light_irq_above_upper(ev[13]), .light_irq_below_lower(ev[12]),
		.prox1_irq_above_upper(ev[11]), .prox1_irq_below_lower(ev[10]),
		.prox0_irq_above_upper(ev[9]), .prox0_irq_below_lower(ev[8]),
		.light_sat_summary(lss), .system_irq_summary(sis)
	);

	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one-cycle event pulse
	task pulse(input logic [19:0] m);
		@(posedge sys_clk);
		#1;
		ev = m;
		@(posedge sys_clk);
		#1;
		ev = '0;
	endtask

	task t_reset;
		logic [7:0] ad [5] = '{`SSF_ADDR_SAT, `SSF_ADDR_ERR, `SSF_ADDR_SYS, 8'hBC, `SSF_ADDR_CAUSE};
		foreach (ad[i])
		begin
			i_ssf_host.rd(ad[i], q);
			chk(q, 8'h00);
		end
		$display("reset test done");
	endtask

	task t_sat;
		for (int i = 0; i < 8; i++)
		begin
			pulse(20'h1 << i);
			chk(lss, 8'h01);
			i_ssf_host.rd(`SSF_ADDR_SAT, q);
			chk(q, 8'h1 << i);
			chk(lss, 8'h00);
		end
		$display("saturation test done");
	endtask

	task t_err;
		lv[2:0] = 3'b111;
		pulse(20'h3C000);
		i_ssf_host.rd(`SSF_ADDR_ERR, q);
		chk(q, 8'hBF);
		lv[2:0] = 3'b000;
		i_ssf_host.rd(`SSF_ADDR_ERR, q);
		chk(q, 8'h10);
		i_ssf_host.wr(`SSF_ADDR_ERR, 8'hFF);
		i_ssf_host.rd(`SSF_ADDR_ERR, q);
		chk(q, 8'h00);
		$display("engine error test done");
	endtask

	task t_sys;
		lv[4:3] = 2'b10;
		pulse(20'h40000);
		chk(sis, 8'h00);
		i_ssf_host.rd(`SSF_ADDR_SYS, q);
		chk(q, 8'h00);
		lv[3] = 1'b1;
		pulse(20'h40000);
		chk(sis, 8'h01);
		i_ssf_host.rd(`SSF_ADDR_SYS, q);
		chk(q, 8'h08);
		lv[4] = 1'b0;
		pulse(20'h80000);
		chk(sis, 8'h00);
		i_ssf_host.rd(`SSF_ADDR_SYS, q);
		chk(q, 8'h01);
		$display("system interrupt test done");
	endtask

	task t_cause;
		pulse(20'h03F00);
		i_ssf_host.wr(`SSF_ADDR_CAUSE, 8'hFF);
		i_ssf_host.rd(`SSF_ADDR_CAUSE, q);
		chk(q, 8'hCF);
		chk(i_ssf_host.nak[7:0], 8'h00);
		chk({7'h00, sda_out}, 8'h00);
		$display("threshold cause test done");
	endtask

	initial
	begin
		srst = 1'b1;
		repeat (20) @(posedge sys_clk);
		#1;
		srst = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		t_reset();
		t_sat();
		t_err();
		t_sys();
		t_cause();
		stop_test();
	end

	// watchdog against a hung bus
	initial
	begin
		#3000000;
		err_count++;
		stop_test();
	end
endmodule // ssf_status_flags_tb

bind ssf_status_flags ssf_status_flags_sva i_ssf_status_flags_sva (
	.sys_clk, .srst, .clk_en, .scl_in, .sda_oe, .light_ch_analog_sat, .flicker_result_changed,
	.flicker_sys_irq_enable, .sync_error_event, .sys_irq_enable, .light_sat_summary, .system_irq_summary
);

`default_nettype wire
